// *** ptrc_consts.vh ***
// Constants for the paper tape reader control block.
// Assumes a 32-bit AXI4-Lite register bus with word-aligned registers.
`ifndef PTRC_CONSTS_VH
`define PTRC_CONSTS_VH

// Register byte offsets.
`define PTRC_REG_CMD 8'h00
`define PTRC_REG_ADDR 8'h04
`define PTRC_REG_DATA 8'h08
`define PTRC_REG_STATE 8'h0c
`define PTRC_REG_ALARMS 8'h10
`define PTRC_REG_IRQ_STATUS 8'h14
`define PTRC_REG_IRQ_MASK 8'h18

// Command register fields: opcode in [2:0], channel address in [7:4].
`define PTRC_CMD_OP_LSB 0
`define PTRC_CMD_OP_MSB 2
`define PTRC_CMD_ADDR_LSB 4
`define PTRC_CMD_ADDR_MSB 7

// Command opcodes.
`define PTRC_OP_OPERATE 3'h1
`define PTRC_OP_ABORT 3'h2
`define PTRC_OP_READY_TEST 3'h3
`define PTRC_OP_ERROR_TEST 3'h4
`define PTRC_OP_INPUT 3'h5
`define PTRC_OP_BLOCK_STEP 3'h6
`define PTRC_OP_ALARM_CLEAR 3'h7

// Reset values.
`define PTRC_ADDR_RESET 4'h0
`define PTRC_MASK_RESET 4'h0

// Interrupt status bit positions.
`define PTRC_IRQ_DATA 0
`define PTRC_IRQ_END_RECORD 1
`define PTRC_IRQ_CHAN_READY 2
`define PTRC_IRQ_ALARM 3

// Tape codes, decoded on the seven data bits.
`define PTRC_CODE_STX 7'h02
`define PTRC_CODE_DC3 7'h13

// Bus responses.
`define PTRC_RESP_OKAY 2'h0
`define PTRC_RESP_SLVERR 2'h2

`endif

// *** ptrc_top.v ***
// Paper tape reader control: starts the reader, captures sprocket-timed
// frames, raises character and end-of-record interrupts and reports alarms.
// Assumes reader pins are asynchronous to aclk and a 32-bit AXI4-Lite master.
//
// Behaviour
// - Busy clears on device-disable code or abort.
// - Ready test: not busy, no demand, address match.
// - Read button: synchronise, demand, clear busy, interrupt.
// - Operate sets busy, clears enable and test.
// - Operate ignores any accompanying accumulator code.
// - All frames loaded; only start-of-text enables data ready.
// - Strobe sets sequence, then control; clear between.
// - Start-of-text while busy sets enable on pulse.
// - Enable lets pulse set ready; exchange interrupt needs ready and sequence control.
// - Input presents data and clears data ready in the same clock.
// - Device-disable clears busy and clutch; end-record low.
// - Data interrupt unmaskable; end-record interrupt maskable.
// - Parity error on input sets the alarm.
// - New frame while data ready sets timing alarm.
// - Error test reports alarms one, two, four.
`timescale 1ns/1ns
`default_nettype none
`include "ptrc_consts.vh"

module ptrc_top (
   // Clock and synchronous active-low reset.
   input wire aclk,
   input wire aresetn,
   // AXI4-Lite write address channel.
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   // AXI4-Lite write data channel.
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   // AXI4-Lite write response channel.
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   // AXI4-Lite read address channel.
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   // AXI4-Lite read data channel.
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // Reader pins, all asynchronous to aclk.
   input wire sprocket_strobe_n,
   input wire [7:0] frame_bits,
   input wire read_button,
   input wire device_online,
   input wire power_ok,
   input wire tape_ok,
   // Reader clutch drive.
   output reg clutch_flag,
   // Processor-side lines.
   output wire ready_test_line,
   output wire data_exchange_irq,
   output wire end_record_irq_n,
   output wire irq
);

   // ----------------------------------------------------------------
   // Functions
   // ----------------------------------------------------------------

   // Compares the seven data bits of a frame with a tape code.
   function is_code;
      input [7:0] frame;
      input [6:0] code;
      begin
         is_code = (frame[6:0] == code);
      end
   endfunction

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------

   reg [1:0] strobe_sync; // Two stages for the sprocket strobe.
   reg [7:0] frame_meta; // First stage for the frame bits.
   reg [7:0] frame_sync; // Second stage for the frame bits.
   reg [1:0] button_sync; // Two stages for the read button.
   reg button_prev; // Previous synchronised button level.
   reg [1:0] online_sync; // Two stages for the on-line level.
   reg [1:0] power_sync; // Two stages for the power level.
   reg [1:0] tape_sync; // Two stages for the tape level.

   // Every pin passes two flip-flops; only the second stage is read.
   always @(posedge aclk) begin
      if (!aresetn) begin
         strobe_sync <= 2'h0;
         frame_meta <= 8'h00;
         frame_sync <= 8'h00;
         button_sync <= 2'h0;
         button_prev <= 1'b0;
         online_sync <= 2'h0;
         power_sync <= 2'h0;
         tape_sync <= 2'h0;
      end else begin
         strobe_sync <= {strobe_sync[0], ~sprocket_strobe_n};
         frame_meta <= frame_bits;
         frame_sync <= frame_meta;
         button_sync <= {button_sync[0], read_button};
         button_prev <= button_sync[1];
         online_sync <= {online_sync[0], device_online};
         power_sync <= {power_sync[0], power_ok};
         tape_sync <= {tape_sync[0], tape_ok};
      end
   end

   wire strobe_active = strobe_sync[1]; // Sprocket hole under the diodes.
   wire online = online_sync[1]; // Reader is on-line.
   wire button_press = button_sync[1] & ~button_prev;

   // ----------------------------------------------------------------
   // Register bus handshake
   // ----------------------------------------------------------------

   reg aw_have; // Write address held.
   reg w_have; // Write data held.
   reg [7:0] aw_addr; // Held write address.
   reg [31:0] w_data; // Held write data.
   reg [3:0] w_strb; // Held byte strobes.

   assign s_axi_awready = ~aw_have & ~s_axi_bvalid;
   assign s_axi_wready = ~w_have & ~s_axi_bvalid;
   assign s_axi_arready = ~s_axi_rvalid;

   // A write is performed once address and data are both held.
   wire wr_go = aw_have & w_have & ~s_axi_bvalid;
   wire wr_low = wr_go & w_strb[0]; // Low byte carries every field.
   wire rd_go = s_axi_arvalid & s_axi_arready;

   // Software command decode.
   wire cmd_wr = wr_low & (aw_addr == `PTRC_REG_CMD);
   wire [2:0] cmd_op = w_data[`PTRC_CMD_OP_MSB:`PTRC_CMD_OP_LSB];
   wire [3:0] cmd_addr = w_data[`PTRC_CMD_ADDR_MSB:`PTRC_CMD_ADDR_LSB];

   reg [3:0] chan_addr; // Channel address this block answers to.
   wire addr_match = (cmd_addr == chan_addr);
   wire cmd_valid = cmd_wr & addr_match;
   // Operate is decoded from the opcode and channel address; data bits above them are unused.
   wire op_operate = cmd_valid & (cmd_op == `PTRC_OP_OPERATE);
   wire op_abort = cmd_valid & (cmd_op == `PTRC_OP_ABORT);
   wire op_rtest = cmd_wr & (cmd_op == `PTRC_OP_READY_TEST);
   wire op_etest = cmd_valid & (cmd_op == `PTRC_OP_ERROR_TEST);
   wire op_input = cmd_valid & ((cmd_op == `PTRC_OP_INPUT) | (cmd_op == `PTRC_OP_BLOCK_STEP));
   wire op_aclear = cmd_valid & (cmd_op == `PTRC_OP_ALARM_CLEAR);

   // ----------------------------------------------------------------
   // Frame sequencing
   // ----------------------------------------------------------------

   reg channel_busy_flag; // Channel is reading a record.
   reg data_ready_enable_flag; // Start-of-text has been seen.
   reg data_ready_flag; // A character waits for input.
   reg sequence_flag; // Sprocket hole present, frame window open.
   reg sequence_control_flag; // Sequence flag delayed by one clock.
   reg manual_demand_flag; // Read button demand pending.
   reg alarm_flag; // Parity or timing error seen.
   reg [7:0] data_register; // Captured frame.
   reg [7:0] input_word; // Frame presented to the processor.
   reg input_parity_ok; // Parity of the presented frame.
   reg test_line; // Result of the last ready test.
   reg [3:0] alarm_word; // Result of the last error test.

   // Window opens with sequence; clear in the gap cycle.
   wire load_window = sequence_flag;
   wire data_register_clear = sequence_flag & ~sequence_control_flag;
   // Control pulse at the trailing edge of the window.
   wire control_pulse = sequence_control_flag & ~sequence_flag;
   wire is_stx = is_code(data_register, `PTRC_CODE_STX);
   wire is_dc3 = is_code(data_register, `PTRC_CODE_DC3);
   // Device-disable code decoded on the control pulse.
   wire dc3_stop = control_pulse & channel_busy_flag & is_dc3;
   // Even parity over all eight frame bits.
   wire parity_ok_signal = ~(^data_register);
   // Timing error: new window opens with data still unread.
   wire timing_error = data_register_clear & data_ready_flag;
   wire parity_error = op_input & ~parity_ok_signal;
   wire alarm_gate = timing_error | parity_error;

   // Sequence and sequence-control flags, and the data register.
   always @(posedge aclk) begin
      if (!aresetn) begin
         sequence_flag <= 1'b0;
         sequence_control_flag <= 1'b0;
         data_register <= 8'h00;
      end else begin
         sequence_flag <= strobe_active & clutch_flag;
         sequence_control_flag <= sequence_flag;
         // Every frame is loaded during the window.
         if (data_register_clear) begin
            data_register <= 8'h00;
         end else if (load_window) begin
            data_register <= data_register | frame_sync;
         end
      end
   end

   // ----------------------------------------------------------------
   // Channel control flags
   // ----------------------------------------------------------------

   // Busy, clutch, enable, data ready and demand.
   always @(posedge aclk) begin
      if (!aresetn) begin
         channel_busy_flag <= 1'b0;
         clutch_flag <= 1'b0;
         data_ready_enable_flag <= 1'b0;
         data_ready_flag <= 1'b0;
         manual_demand_flag <= 1'b0;
      end else begin
         // Busy: operate sets, the clearing causes reset it.
         if (op_operate) begin
            channel_busy_flag <= 1'b1;
         end else if (op_abort | dc3_stop | button_press) begin
            channel_busy_flag <= 1'b0;
         end
         // Clutch follows busy while on-line; device-disable drops it at once.
         if (dc3_stop) begin
            clutch_flag <= 1'b0;
         end else begin
            // Clutch engages while busy and on-line.
            clutch_flag <= channel_busy_flag & online;
         end
         // Data ready enable.
         if (op_operate) begin
            data_ready_enable_flag <= 1'b0;
         end else if (control_pulse & channel_busy_flag & is_stx) begin
            data_ready_enable_flag <= 1'b1;
         end
         // Data ready: a new character wins over a same-cycle input clear.
         if (control_pulse & data_ready_enable_flag & channel_busy_flag & ~is_dc3) begin
            data_ready_flag <= 1'b1;
         end else if (op_input) begin
            data_ready_flag <= 1'b0;
         end
         // Manual demand: set by the button, served by operate.
         if (button_press) begin
            manual_demand_flag <= 1'b1;
         end else if (op_operate) begin
            manual_demand_flag <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Processor transfers and tests
   // ----------------------------------------------------------------

   // Input word, test line, alarm flag and alarm word.
   always @(posedge aclk) begin
      if (!aresetn) begin
         input_word <= 8'h00;
         input_parity_ok <= 1'b1;
         test_line <= 1'b0;
         alarm_flag <= 1'b0;
         alarm_word <= 4'h0;
      end else begin
         // Present the data register on input.
         if (op_input) begin
            input_word <= data_register;
            input_parity_ok <= parity_ok_signal;
         end
         // Test line answers the last ready test; operate drops it.
         if (op_operate) begin
            test_line <= 1'b0;
         end else if (op_rtest) begin
            // Ready only when idle, no demand, addressed.
            test_line <= ~channel_busy_flag & ~manual_demand_flag & addr_match;
         end
         // Alarm: an error in the clearing cycle still sets it.
         if (alarm_gate) begin
            // Parity or timing error sets the alarm.
            alarm_flag <= 1'b1;
         end else if (op_aclear) begin
            alarm_flag <= 1'b0;
         end
         // Alarm 1 off-line, 2 power or tape, 3 never, 4 error.
         if (op_etest) begin
            alarm_word <= {alarm_flag, 1'b0, ~power_sync[1] | ~tape_sync[1], ~online};
         end
      end
   end

   assign ready_test_line = test_line;
   // Exchange interrupt with data ready and sequence control.
   assign data_exchange_irq = data_ready_flag & sequence_control_flag;
   // End-of-record line low while busy is clear.
   assign end_record_irq_n = channel_busy_flag;

   // ----------------------------------------------------------------
   // Interrupt status and mask
   // ----------------------------------------------------------------

   reg [3:0] irq_status; // Sticky event bits, write one to clear.
   reg [3:0] irq_mask; // Enables for the maskable bits.
   reg busy_prev; // Busy one clock ago.
   reg ready_prev; // Data ready one clock ago.
   wire [3:0] irq_events; // Events of this clock.
   wire [3:0] irq_clear; // Software clear pulses.

   assign irq_events = {alarm_gate, button_press, busy_prev & ~channel_busy_flag,
                        data_ready_flag & ~ready_prev};
   assign irq_clear = (wr_low & (aw_addr == `PTRC_REG_IRQ_STATUS)) ? w_data[3:0] : 4'h0;

   // A set in the same cycle as its clear wins.
   always @(posedge aclk) begin
      if (!aresetn) begin
         irq_status <= 4'h0;
         busy_prev <= 1'b0;
         ready_prev <= 1'b0;
      end else begin
         irq_status <= irq_events | (irq_status & ~irq_clear);
         busy_prev <= channel_busy_flag;
         ready_prev <= data_ready_flag;
      end
   end

   // Data bit ignores the mask; the rest are maskable.
   assign irq = irq_status[`PTRC_IRQ_DATA] | (|(irq_status[3:1] & irq_mask[3:1]));

   // ----------------------------------------------------------------
   // Register bus transactions
   // ----------------------------------------------------------------

   // Read data for an address.
   reg [31:0] next_rdata;
   reg next_rresp_err;
   always @* begin
      next_rdata = 32'h00000000;
      next_rresp_err = 1'b0;
      case (s_axi_araddr)
         `PTRC_REG_CMD: next_rdata = 32'h00000000;
         `PTRC_REG_ADDR: next_rdata = {28'h0000000, chan_addr};
         `PTRC_REG_DATA: next_rdata = {23'h000000, input_parity_ok, input_word};
         `PTRC_REG_STATE: next_rdata = {21'h000000, end_record_irq_n, data_exchange_irq, test_line,
                                        alarm_flag, manual_demand_flag, data_ready_flag,
                                        data_ready_enable_flag, sequence_control_flag,
                                        sequence_flag, clutch_flag, channel_busy_flag};
         `PTRC_REG_ALARMS: next_rdata = {28'h0000000, alarm_word};
         `PTRC_REG_IRQ_STATUS: next_rdata = {28'h0000000, irq_status};
         `PTRC_REG_IRQ_MASK: next_rdata = {28'h0000000, irq_mask};
         default: next_rresp_err = 1'b1;
      endcase
   end

   // Write acceptance, register writes and both responses.
   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_have <= 1'b0;
         w_have <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `PTRC_RESP_OKAY;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `PTRC_RESP_OKAY;
         chan_addr <= `PTRC_ADDR_RESET;
         irq_mask <= `PTRC_MASK_RESET;
      end else begin
         // Address and data are taken in either order.
         if (s_axi_awvalid & s_axi_awready) begin
            aw_have <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid & s_axi_wready) begin
            w_have <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         // Perform the write and answer it.
         if (wr_go) begin
            aw_have <= 1'b0;
            w_have <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= `PTRC_RESP_OKAY;
            case (aw_addr)
               `PTRC_REG_ADDR: begin
                  if (w_strb[0]) begin
                     chan_addr <= w_data[3:0];
                  end
               end
               `PTRC_REG_IRQ_MASK: begin
                  if (w_strb[0]) begin
                     irq_mask <= w_data[3:0];
                  end
               end
               `PTRC_REG_CMD, `PTRC_REG_IRQ_STATUS: begin
                  s_axi_bresp <= `PTRC_RESP_OKAY;
               end
               // Read-only and unmapped addresses refuse writes.
               default: s_axi_bresp <= `PTRC_RESP_SLVERR;
            endcase
         end else if (s_axi_bvalid & s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         // Read answer one clock after the address is taken.
         if (rd_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rresp_err ? `PTRC_RESP_SLVERR : `PTRC_RESP_OKAY;
         end else if (s_axi_rvalid & s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

endmodule
`default_nettype wire

// *** ptrc_properties.sv ***
// Port checker for the tape reader control block.
// Assumes it is bound to ptrc_top and sees its ports only.
`timescale 1ns/1ns
`default_nettype none
module ptrc_props (
   // Clock and reset.
   input wire aclk,
   input wire aresetn,
   // Bus handshakes.
   input wire s_axi_awready,
   input wire s_axi_bvalid,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire s_axi_rvalid,
   // Reader and processor lines.
   input wire read_button,
   input wire device_online,
   input wire clutch_flag,
   input wire data_exchange_irq,
   input wire end_record_irq_n,
   input wire irq
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   rst_clear_a: assert property ($rose(aresetn) |-> !clutch_flag && !end_record_irq_n && !irq)
      else $error("flags not clear after reset");
   clutch_busy_a: assert property ($rose(clutch_flag) |-> $past(end_record_irq_n))
      else $error("clutch engaged while idle");
   clutch_start_a: assert property ($rose(end_record_irq_n) && device_online |-> ##[1:4] clutch_flag)
      else $error("clutch not engaged after start");
   clutch_stop_a: assert property ($fell(end_record_irq_n) |=> !clutch_flag)
      else $error("clutch held after end of record");
   button_idle_a: assert property ($rose(read_button) |-> ##[2:6] !end_record_irq_n)
      else $error("button did not free channel");
   exch_unmasked_a: assert property ($rose(data_exchange_irq) |-> irq)
      else $error("exchange interrupt not presented");
   write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready)
      else $error("write address taken during response");
   read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   // Main scenarios reached.
   cover property ($fell(end_record_irq_n));
   cover property ($rose(data_exchange_irq));
   cover property ($rose(read_button));
endmodule
bind ptrc_top ptrc_props u_props (.aclk, .aresetn, .s_axi_awready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rvalid, .read_button, .device_online, .clutch_flag, .data_exchange_irq, .end_record_irq_n, .irq);
`default_nettype wire

// *** ptrc_reader.sv ***
// Behavioural paper tape reader: feeds frames while the clutch is engaged.
// Assumes the bench fills the tape queue while the clutch is released.
`timescale 1ns/1ns
`default_nettype none
module ptrc_reader (
   // Clutch drive from the control block.
   input wire clutch_flag,
   // Sprocket and photodiode outputs.
   output logic sprocket_strobe_n,
   output logic [7:0] frame_bits
);
   logic [7:0] tape[$]; // Frames left; bit 7 set asks for a bad parity.
   int idle = 40; // One less than the still sprocket periods between frames, sets the tape speed.
   logic [7:0] f; // Frame being fed.
   // Feeds one frame per slot; the strobe stands high outside frames.
   initial begin
      sprocket_strobe_n = 1'b1;
      frame_bits = 8'h00;
      #7;
      forever begin
         repeat (idle + 1) #160;
         if (clutch_flag && tape.size() > 0) begin
            f = tape.pop_front();
            // seven data bits and even parity
            frame_bits = {^f, f[6:0]};
            sprocket_strobe_n = 1'b0;
            #80 sprocket_strobe_n = 1'b1;
            // Hold time over, so the lines no longer show the frame.
            #70 frame_bits = ~frame_bits;
         end
      end
   end
endmodule
`default_nettype wire

// *** ptrc_top_tb.sv ***
// Self-checking bench for the tape reader control block.
// Assumes the reader model and the bound checker are compiled alongside.
`timescale 1ns/1ns
`default_nettype none
`include "ptrc_consts.vh"
module ptrc_top_tb;
   logic aclk = 1'b0, aresetn = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic read_button = 1'b0, device_online = 1'b1, power_ok = 1'b1, tape_ok = 1'b1;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   wire sprocket_strobe_n, clutch_flag, ready_test_line, data_exchange_irq, end_record_irq_n, irq;
   wire [7:0] frame_bits;
   int fail_count = 0, n_compared = 0;
   ptrc_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf),
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sprocket_strobe_n, .frame_bits,
      .read_button, .device_online, .power_ok, .tape_ok, .clutch_flag, .ready_test_line, .data_exchange_irq,
      .end_record_irq_n, .irq);
   ptrc_reader rdr (.clutch_flag, .sprocket_strobe_n, .frame_bits);
   initial forever #10 aclk = ~aclk;
   // Compares and counts; reports a difference at once.
   task automatic chk(input logic [33:0] got, input logic [33:0] exp);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic pin(input logic v, input logic e);
      chk({33'h0, v}, {33'h0, e});
   endtask
   // One bus transfer; each channel is released at the edge that takes it.
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
      output logic [1:0] r);
      logic done, ta, tw, tr;
      done = 1'b0;
      @(posedge aclk);
      if (w) begin
         s_axi_awaddr <= a;
         s_axi_wdata <= d;
         s_axi_awvalid <= 1'b1;
         s_axi_wvalid <= 1'b1;
         s_axi_bready <= 1'b1;
      end else begin
         s_axi_araddr <= a;
         s_axi_arvalid <= 1'b1;
         s_axi_rready <= 1'b1;
      end
      while (!done) begin
         @(negedge aclk);
         ta = s_axi_awvalid && s_axi_awready;
         tw = s_axi_wvalid && s_axi_wready;
         tr = s_axi_arvalid && s_axi_arready;
         done = w ? s_axi_bvalid : s_axi_rvalid;
         q = s_axi_rdata;
         r = w ? s_axi_bresp : s_axi_rresp;
         @(posedge aclk);
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
         if (tr) s_axi_arvalid <= 1'b0;
      end
      s_axi_bready <= 1'b0;
      s_axi_rready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      logic [31:0] q;
      logic [1:0] r;
      bus(1'b0, a, 32'h0, q, r);
      chk({r, q}, {er, e});
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic [31:0] q;
      logic [1:0] r;
      bus(1'b1, a, d, q, r);
      chk({32'h0, r}, {32'h0, er});
   endtask
   task automatic cmd(input logic [7:0] c);
      wr(`PTRC_REG_CMD, {24'h0, c}, `PTRC_RESP_OKAY);
   endtask
   // Waits, bounded, for the interrupt pin (sel 0) or end-of-record pin (sel 1).
   task automatic wait_for(input logic sel, input logic lvl);
      int n;
      n = 0;
      while ((sel ? end_record_irq_n : irq) !== lvl && n < 5000) begin
         @(posedge aclk);
         n++;
      end
      pin(sel ? end_record_irq_n : irq, lvl);
   endtask
   task automatic conclude;
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial begin
      #500000;
      fail_count++;
      conclude;
   end
   initial begin
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      rd(`PTRC_REG_STATE, 32'h0, `PTRC_RESP_OKAY);
      rd(`PTRC_REG_DATA, 32'h100, `PTRC_RESP_OKAY);
      rd(8'h1c, 32'h0, `PTRC_RESP_SLVERR);
      wr(`PTRC_REG_STATE, 32'h1, `PTRC_RESP_SLVERR);
      wr(`PTRC_REG_ADDR, 32'h5, `PTRC_RESP_OKAY);
      cmd(8'h33);
      pin(ready_test_line, 1'b0);
      cmd(8'h53);
      pin(ready_test_line, 1'b1);
      // Leader and inter-record codes, start of text, bad-parity letter, end codes.
      rdr.tape = '{8'h00, 8'h0d, 8'h02, 8'hc1, 8'h03, 8'h13};
      wr(`PTRC_REG_CMD, 32'h0021_0051, `PTRC_RESP_OKAY);
      pin(ready_test_line, 1'b0);
      rd(`PTRC_REG_STATE, 32'h403, `PTRC_RESP_OKAY);
      wait_for(1'b0, 1'b1);
      cmd(8'h55);
      rd(`PTRC_REG_DATA, 32'h0c1, `PTRC_RESP_OKAY);
      rd(`PTRC_REG_STATE, 32'h493, `PTRC_RESP_OKAY);
      wr(`PTRC_REG_IRQ_STATUS, 32'hf, `PTRC_RESP_OKAY);
      cmd(8'h54);
      rd(`PTRC_REG_ALARMS, 32'h8, `PTRC_RESP_OKAY);
      cmd(8'h57);
      wait_for(1'b0, 1'b1);
      cmd(8'h56);
      rd(`PTRC_REG_DATA, 32'h103, `PTRC_RESP_OKAY);
      wr(`PTRC_REG_IRQ_STATUS, 32'h1, `PTRC_RESP_OKAY);
      wait_for(1'b1, 1'b0);
      rd(`PTRC_REG_STATE, 32'h10, `PTRC_RESP_OKAY);
      pin(irq, 1'b0);
      wr(`PTRC_REG_IRQ_MASK, 32'h2, `PTRC_RESP_OKAY);
      pin(irq, 1'b1);
      // Fast tape with no service: the third frame overruns the second.
      rdr.idle = 0;
      rdr.tape = '{8'h02, 8'h42, 8'h43, 8'h13};
      cmd(8'h53);
      pin(ready_test_line, 1'b1);
      cmd(8'h51);
      wait_for(1'b1, 1'b0);
      cmd(8'h54);
      rd(`PTRC_REG_ALARMS, 32'h8, `PTRC_RESP_OKAY);
      cmd(8'h55);
      cmd(8'h57);
      cmd(8'h51);
      pin(end_record_irq_n, 1'b1);
      cmd(8'h52);
      pin(end_record_irq_n, 1'b0);
      wr(`PTRC_REG_IRQ_STATUS, 32'hf, `PTRC_RESP_OKAY);
      cmd(8'h51);
      read_button <= 1'b1;
      repeat (4) @(posedge aclk);
      read_button <= 1'b0;
      repeat (8) @(posedge aclk);
      rd(`PTRC_REG_IRQ_STATUS, 32'h6, `PTRC_RESP_OKAY);
      rd(`PTRC_REG_STATE, 32'h40, `PTRC_RESP_OKAY);
      cmd(8'h53);
      pin(ready_test_line, 1'b0);
      device_online <= 1'b0;
      power_ok <= 1'b0;
      repeat (4) @(posedge aclk);
      cmd(8'h54);
      rd(`PTRC_REG_ALARMS, 32'h3, `PTRC_RESP_OKAY);
      // Back on-line with power, but the tape has run out.
      device_online <= 1'b1;
      power_ok <= 1'b1;
      tape_ok <= 1'b0;
      repeat (4) @(posedge aclk);
      cmd(8'h54);
      rd(`PTRC_REG_ALARMS, 32'h2, `PTRC_RESP_OKAY);
      conclude;
   end
endmodule
`default_nettype wire
